// file: hdl/rre_pkg.sv
// Purpose: Shared constants and carrier types for the return and rotate execution unit
// Assumes: 16-bit instruction words, 8-bit data, 21-bit program counter
// Notes: Status layout keeps carry at bit 0, zero at bit 2, negative at bit 4
package rre_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 21;
	localparam int BANK_W = 4;
	localparam int STAT_W = 5;
	localparam logic [15:0] RET_MASK = 16'hfffe;
	localparam logic [15:0] RET_CODE = 16'h0012;
	localparam logic [5:0] OP_ROT_LEFT_CARRY = 6'h0d;
	localparam logic [5:0] OP_ROT_LEFT_PLAIN = 6'h11;
	localparam logic [5:0] OP_ROT_RIGHT_CARRY = 6'h0c;
	localparam int BIT_DEST = 9;
	localparam int BIT_BANK = 8;
	localparam int BIT_FAST = 0;
	localparam int STAT_C = 0;
	localparam int STAT_Z = 2;
	localparam int STAT_N = 4;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
	localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
	localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] LATCH_RESET = 21'h000000;

	typedef enum logic [3:0]
	{
		RRE_Q1 = 4'h1,
		RRE_Q2 = 4'h2,
		RRE_Q3 = 4'h4,
		RRE_Q4 = 4'h8
	} rre_phase_t;

	typedef struct packed
	{
		logic [DATA_W-1:0] work;
		logic [STAT_W-1:0] flags;
		logic [BANK_W-1:0] bank;
	} rre_ctx_t;

	typedef struct packed
	{
		logic toFile;
		logic indexed;
		logic [11:0] addr;
	} rre_mem_t;
endpackage : rre_pkg

// file: hdl/rre_rotator.sv
// Purpose: Combinational rotate datapath with flag results
// Assumes: Mode selects left-through-carry, left-plain or right-through-carry
// Notes: Carry out equals carry in for the plain rotate
`timescale 1ns/1ps
module rre_rotator
(
	input wire logic [1:0] mode, // 0 left via carry, 1 left plain, 2 right via carry
	input wire logic [7:0] src, // Operand byte
	input wire logic carryIn, // Current carry flag
	output logic [7:0] result, // Rotated byte
	output logic carryOut, // New carry
	output logic zero, // Result is zero
	output logic negative // Result bit 7
);
	always_comb
	begin
		result = src;
		carryOut = carryIn;
		case (mode)
			2'h0:
			begin
				result = {src[6:0], carryIn};
				carryOut = src[7];
			end
			2'h1: result = {src[6:0], src[7]};
			2'h2:
			begin
				result = {carryIn, src[7:1]};
				carryOut = src[0];
			end
			default: result = src;
		endcase
		zero = (result == 8'h00);
		negative = result[7];
	end
endmodule : rre_rotator

// file: hdl/rre_exec.sv
// Purpose: Execution of subroutine return and the three single-register rotates
// Assumes: Instruction presented with instrValid at Q1; file data valid by Q3
//          qTick may be tied high, one instruction then takes four clocks
// Notes: Return stack and shadow capture live outside; this unit pops and restores
//        A latch load from another instruction still lands during a return
//
// How it works
// - Return pops the stack and loads its top value into the PC.
// - Return with fast bit one restores working, flags, bank from shadows.
// - Return with fast bit zero leaves working, flags and bank alone.
// - Return never alters the upper or high PC latch registers.
// - Rotate left through carry decodes as 001101, d, a, 8-bit address.
// - Left through carry: bits shift up, bit 7 to carry, carry to bit 0.
// - Destination bit zero writes working register, one writes the file register.
// - Bank bit zero uses access bank, one uses bank select register.
// - Bank zero, extended set on, address up to 95: indexed literal offset.
// - Plain rotate left 010001: bit 7 into bit 0, flags N and Z only.
`timescale 1ns/1ps
module rre_exec
(
	input wire logic clk, // 25 MHz core clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic qTick, // One-cycle enable advancing the Q phase
	input wire logic instrValid, // Instruction word valid for this instruction cycle
	input wire logic [15:0] instrWord, // Instruction word
	input wire logic extendedSet, // Extended instruction set enabled
	input wire logic [7:0] fileRdData, // File register read data
	input wire logic [rre_pkg::PC_W-1:0] stackTopValue, // Top of return stack
	input wire rre_pkg::rre_ctx_t shadowCtx, // Shadow working, flags, bank select
	input wire logic [rre_pkg::PC_W-1:0] latchWrUpper, // Latch load data, upper
	input wire logic [rre_pkg::PC_W-1:0] latchWrHigh, // Latch load data, high
	input wire logic latchWrEn, // Latch load strobe from other instructions
	output logic [rre_pkg::PC_W-1:0] pcOut, // Program counter
	output rre_pkg::rre_ctx_t ctxOut, // Working, flags, bank select
	output logic [rre_pkg::PC_W-1:0] pcUpperLatch, // Upper PC latch
	output logic [rre_pkg::PC_W-1:0] pcHighLatch, // High PC latch
	output logic stackPop, // One-cycle pop strobe
	output rre_pkg::rre_mem_t fileReq, // File register address and mode
	output logic fileRd, // File read strobe
	output logic fileWr, // File write strobe
	output logic [7:0] fileWrData, // File write data
	output rre_pkg::rre_phase_t phaseOut // Current Q phase
);
	////////////////////////////////////////////////////////////////////////////////
	rre_pkg::rre_phase_t phase_reg, phase_next;
	logic [rre_pkg::PC_W-1:0] pc_reg, pc_next;
	rre_pkg::rre_ctx_t ctx_reg, ctx_next;
	logic [rre_pkg::PC_W-1:0] upper_reg, upper_next, high_reg, high_next;
	logic pop_reg, pop_next, rd_reg, rd_next, wr_reg, wr_next;
	logic [7:0] wdata_reg, wdata_next;
	rre_pkg::rre_mem_t req_reg, req_next;
	logic [15:0] ir_reg, ir_next;
	logic isRet, isRot;
	logic [1:0] rotMode;
	logic [7:0] rotResult;
	logic rotCarry, rotZero, rotNeg;

	////////////////////////////////////////////////////////////////////////////////
	// Decode from the held word so a changing bus mid-cycle cannot split behaviour
	always_comb
	begin
		isRet = ((ir_reg & rre_pkg::RET_MASK) == rre_pkg::RET_CODE);
		isRot = 1'b1;
		// Mode 3 passes data through and only shows when nothing rotates
		rotMode = 2'h3;
		case (ir_reg[15:10])
			rre_pkg::OP_ROT_LEFT_CARRY: rotMode = 2'h0;
			rre_pkg::OP_ROT_LEFT_PLAIN: rotMode = 2'h1;
			rre_pkg::OP_ROT_RIGHT_CARRY: rotMode = 2'h2;
			default: isRot = 1'b0;
		endcase
	end

	rre_rotator u_rot
	(
		.mode(rotMode),
		.src(fileRdData),
		.carryIn(ctx_reg.flags[rre_pkg::STAT_C]),
		.result(rotResult),
		.carryOut(rotCarry),
		.zero(rotZero),
		.negative(rotNeg)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next values of every register; the block below only stores them
	always_comb
	begin
		phase_next = phase_reg;
		pc_next = pc_reg;
		ctx_next = ctx_reg;
		upper_next = upper_reg;
		high_next = high_reg;
		pop_next = 1'b0;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		req_next = req_reg;
		ir_next = ir_reg;
		// Only other instructions load the latches; return never touches them
		if (latchWrEn)
		begin
			upper_next = latchWrUpper;
			high_next = latchWrHigh;
		end
		if (qTick)
		begin
			case (phase_reg)
				rre_pkg::RRE_Q1:
				begin
					phase_next = rre_pkg::RRE_Q2;
					ir_next = instrValid ? instrWord : 16'h0000;
				end
				rre_pkg::RRE_Q2:
				begin
					phase_next = rre_pkg::RRE_Q3;
					if (isRot)
					begin
						req_next.toFile = ir_reg[rre_pkg::BIT_DEST];
						// Indexed mode is only flagged; the offset add sits in the address unit
						req_next.indexed = 1'b0;
						if (ir_reg[rre_pkg::BIT_BANK])
							req_next.addr = {ctx_reg.bank, ir_reg[7:0]};
						else if (extendedSet && ir_reg[7:0] <= rre_pkg::INDEXED_LIMIT)
						begin
							req_next.indexed = 1'b1;
							req_next.addr = {4'h0, ir_reg[7:0]};
						end
						// Access bank: low addresses map to bank 0, the rest to bank f
						else if (ir_reg[7:0] < rre_pkg::ACCESS_SPLIT)
							req_next.addr = {4'h0, ir_reg[7:0]};
						else
							req_next.addr = {4'hf, ir_reg[7:0]};
						rd_next = 1'b1;
					end
				end
				rre_pkg::RRE_Q3:
				begin
					phase_next = rre_pkg::RRE_Q4;
					if (isRot)
					begin
						// Carry survives the plain rotate because the rotator passes it through
						ctx_next.flags[rre_pkg::STAT_C] = rotCarry;
						ctx_next.flags[rre_pkg::STAT_Z] = rotZero;
						ctx_next.flags[rre_pkg::STAT_N] = rotNeg;
						// Destination bit picks write-back to the file or the working register
						if (ir_reg[rre_pkg::BIT_DEST])
						begin
							wr_next = 1'b1;
							wdata_next = rotResult;
						end
						else
							ctx_next.work = rotResult;
					end
				end
				rre_pkg::RRE_Q4:
				begin
					phase_next = rre_pkg::RRE_Q1;
					// The second return cycle is fed in as a no-op word, so all work happens here
					if (isRet)
					begin
						pc_next = stackTopValue;
						pop_next = 1'b1;
						if (ir_reg[rre_pkg::BIT_FAST])
							ctx_next = shadowCtx;
						else
							ctx_next = ctx_reg;
						// Latches untouched here so a coincident load from elsewhere is not lost
					end
				end
				default: phase_next = rre_pkg::RRE_Q1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Plain storage; reset loads package constants and zero literals
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_reg <= rre_pkg::RRE_Q1;
			pc_reg <= rre_pkg::PC_RESET;
			ctx_reg <= {rre_pkg::WORK_RESET, rre_pkg::STAT_RESET, rre_pkg::BANK_RESET};
			upper_reg <= rre_pkg::LATCH_RESET;
			high_reg <= rre_pkg::LATCH_RESET;
			pop_reg <= 1'b0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= 8'h00;
			req_reg <= '0;
			ir_reg <= 16'h0000;
		end
		else
		begin
			phase_reg <= phase_next;
			pc_reg <= pc_next;
			ctx_reg <= ctx_next;
			upper_reg <= upper_next;
			high_reg <= high_next;
			pop_reg <= pop_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			req_reg <= req_next;
			ir_reg <= ir_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every output is a register, never decoded logic
	assign pcOut = pc_reg;
	assign ctxOut = ctx_reg;
	assign pcUpperLatch = upper_reg;
	assign pcHighLatch = high_reg;
	assign stackPop = pop_reg;
	assign fileReq = req_reg;
	assign fileRd = rd_reg;
	assign fileWr = wr_reg;
	assign fileWrData = wdata_reg;
	assign phaseOut = phase_reg;
endmodule : rre_exec

// file: sim/rre_exec_chk.sv
// Purpose: Port checks for the return and rotate unit
// Assumes: Word is latched at the Q1 tick
// Notes: Bound to every rre_exec
`timescale 1ns/1ps
module rre_exec_chk
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic qTick, // Phase enable
	input wire logic instrValid, // Word valid
	input wire logic [15:0] instrWord, // Word
	input wire logic extendedSet, // Extended set
	input wire logic [7:0] fileRdData, // Read data
	input wire logic [rre_pkg::PC_W-1:0] stackTopValue, // Stack top
	input wire rre_pkg::rre_ctx_t shadowCtx, // Shadows
	input wire logic latchWrEn, // Latch load
	input wire logic [rre_pkg::PC_W-1:0] pcOut, // PC
	input wire rre_pkg::rre_ctx_t ctxOut, // Context
	input wire logic [rre_pkg::PC_W-1:0] pcUpperLatch, // Upper latch
	input wire logic [rre_pkg::PC_W-1:0] pcHighLatch, // High latch
	input wire logic stackPop, // Pop
	input wire rre_pkg::rre_mem_t fileReq, // File request
	input wire logic fileRd, // Read strobe
	input wire logic fileWr, // Write strobe
	input wire logic [7:0] fileWrData, // Write data
	input wire rre_pkg::rre_phase_t phaseOut // Phase
);
	logic [15:0] wordReg;
	logic [7:0] rdPrev;
	logic cPrev;
	logic [5:0] op;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	assign op = wordReg[15:10];
	// The word is gone from the inputs long before write-back, so keep it
	always_ff @(posedge clk)
	begin
		if (qTick && phaseOut == rre_pkg::RRE_Q1 && instrValid)
			wordReg <= instrWord;
		rdPrev <= fileRdData;
		cPrev <= ctxOut.flags[rre_pkg::STAT_C];
	end
	a_pop_loads_pc: assert property (stackPop |-> pcOut == $past(stackTopValue))
		else $error("pc not loaded from stack top");
	a_fast_restore: assert property (stackPop && wordReg[0]
		|-> ctxOut == $past(shadowCtx))
		else $error("shadow context not restored");
	a_slow_keep: assert property (stackPop && !wordReg[0] |-> $stable(ctxOut))
		else $error("context changed on plain return");
	a_latch_hold: assert property (!$past(latchWrEn)
		|-> $stable(pcUpperLatch) && $stable(pcHighLatch))
		else $error("pc latch changed without load");
	a_dest_select: assert property (fileWr |-> fileReq.toFile && wordReg[9])
		else $error("write to file with working destination");
	a_left_carry: assert property (fileWr && op == rre_pkg::OP_ROT_LEFT_CARRY
		|-> fileWrData == {rdPrev[6:0], cPrev} && ctxOut.flags[0] == rdPrev[7])
		else $error("left rotate via carry wrong");
	a_left_plain: assert property (fileWr && op == rre_pkg::OP_ROT_LEFT_PLAIN
		|-> fileWrData == {rdPrev[6:0], rdPrev[7]} && ctxOut.flags[0] == cPrev)
		else $error("plain left rotate wrong");
	a_right_carry: assert property (fileWr && op == rre_pkg::OP_ROT_RIGHT_CARRY
		|-> fileWrData == {cPrev, rdPrev[7:1]} && ctxOut.flags[0] == rdPrev[0])
		else $error("right rotate via carry wrong");
	a_index_mode: assert property (fileRd |-> fileReq.indexed ==
		($past(extendedSet) && !wordReg[8] && wordReg[7:0] <= 8'h5f))
		else $error("indexed mode wrong");
	a_bank_addr: assert property (fileRd && !fileReq.indexed |-> fileReq.addr ==
		(wordReg[8] ? {ctxOut.bank, wordReg[7:0]} : {{4{wordReg[7:0] >= 8'h60}}, wordReg[7:0]}))
		else $error("file address wrong");
	c_pop: cover property (stackPop && wordReg[0]);
	c_plain_return: cover property (stackPop && !wordReg[0]);
	c_write: cover property (fileWr);
	c_index: cover property (fileRd && fileReq.indexed);
endmodule : rre_exec_chk
bind rre_exec rre_exec_chk chk_u (.clk, .rst, .qTick, .instrValid, .instrWord, .extendedSet,
	.fileRdData, .stackTopValue, .shadowCtx, .latchWrEn, .pcOut, .ctxOut, .pcUpperLatch,
	.pcHighLatch, .stackPop, .fileReq, .fileRd, .fileWr, .fileWrData, .phaseOut);

// file: sim/rre_exec_tb_top.sv
// Purpose: Self-checking bench for the return and rotate unit
// Assumes: qTick held high, one instruction per four cycles
// Notes: Carry chains from row to row
`timescale 1ns/1ps
module rre_exec_tb_top;
	typedef struct {logic [15:0] w; logic [7:0] d; logic [7:0] v; logic [4:0] f;} rre_row_t;
	rre_row_t rows [6] = '{'{16'h3480, 8'he6, 8'hcc, 5'h11}, '{16'h3712, 8'h01, 8'h03, 5'h00},
		'{16'h4420, 8'hab, 8'h57, 5'h00}, '{16'h3090, 8'h01, 8'h00, 5'h05},
		'{16'h4734, 8'h80, 8'h01, 5'h01}, '{16'h3334, 8'h00, 8'h80, 5'h10}};
	logic clk = 1'b0, rst = 1'b1, qTick = 1'b1, instrValid = 1'b0, extendedSet = 1'b0;
	logic latchWrEn = 1'b0, stackPop, fileRd, fileWr, sawRd, sawWr;
	logic [15:0] instrWord = 16'h0000;
	logic [7:0] fileRdData = 8'h00, fileWrData;
	logic [20:0] stackTopValue = 21'h12345, latchWrUpper = 21'h1f0f0, latchWrHigh = 21'h00a5a;
	logic [20:0] pcOut, pcUpperLatch, pcHighLatch;
	rre_pkg::rre_ctx_t shadowCtx = {8'h5a, 5'h15, 4'h3}, ctxOut;
	rre_pkg::rre_mem_t fileReq;
	rre_pkg::rre_phase_t phaseOut;
	int failCount = 0, numChecks = 0;
	rre_exec dut_u (.clk, .rst, .qTick, .instrValid, .instrWord, .extendedSet, .fileRdData,
		.stackTopValue, .shadowCtx, .latchWrUpper, .latchWrHigh, .latchWrEn, .pcOut, .ctxOut,
		.pcUpperLatch, .pcHighLatch, .stackPop, .fileReq, .fileRd, .fileWr, .fileWrData, .phaseOut);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		numChecks++;
		if (got !== exp)
		begin
			failCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Valid only for the Q1 cycle; the other three phases stay idle
	// Read and write strobes are sampled mid-way through their single cycle
	task automatic issue(input logic [15:0] w, input logic [7:0] d);
		instrValid = 1'b1;
		instrWord = w;
		fileRdData = d;
		@(negedge clk);
		instrValid = 1'b0;
		@(negedge clk);
		sawRd = fileRd;
		@(negedge clk);
		sawWr = fileWr;
		@(negedge clk);
	endtask : issue
	task automatic giveVerdict;
		$display("checks=%0d errors=%0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : giveVerdict
	////////////////////////////////////////////////////////////////
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#100000;
		failCount++;
		giveVerdict();
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk({pcOut, ctxOut}, 0);
		chk(phaseOut, rre_pkg::RRE_Q1);
		foreach (rows[i])
		begin
			issue(rows[i].w, rows[i].d);
			chk(rows[i].w[9] ? fileWrData : ctxOut.work, rows[i].v);
			chk(ctxOut.flags, rows[i].f);
			chk({sawRd, sawWr, stackPop}, {1'b1, rows[i].w[9], 1'b0});
			chk(fileReq.toFile, rows[i].w[9]);
		end
		issue(16'h0013, 8'h00);
		chk(pcOut, 21'h12345);
		chk(stackPop, 1'b1);
		chk(ctxOut, {8'h5a, 5'h15, 4'h3});
		// The second return cycle is a no-op; a latch load lands there
		latchWrEn = 1'b1;
		@(negedge clk);
		latchWrEn = 1'b0;
		repeat (3) @(negedge clk);
		issue(16'h3744, 8'h02);
		chk(fileReq.addr, 12'h344);
		chk(fileWrData, 8'h05);
		shadowCtx = 17'h00000;
		stackTopValue = 21'h0abcd;
		issue(16'h0012, 8'h00);
		chk(pcOut, 21'h0abcd);
		chk(stackPop, 1'b1);
		chk(ctxOut, {8'h5a, 5'h00, 4'h3});
		chk({pcUpperLatch, pcHighLatch}, {21'h1f0f0, 21'h00a5a});
		repeat (4) @(negedge clk);
		extendedSet = 1'b1;
		issue(16'h345f, 8'h00);
		chk(fileReq.indexed, 1'b1);
		issue(16'h3460, 8'h00);
		chk({fileReq.indexed, fileReq.addr}, 13'h0f60);
		// Reset mid-instruction must drop the pending rotate and clear all state
		instrValid = 1'b1;
		instrWord = 16'h3712;
		@(negedge clk);
		instrValid = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk({pcOut, ctxOut}, 0);
		chk({pcUpperLatch, pcHighLatch}, 0);
		chk({phaseOut, stackPop, fileRd, fileWr}, {rre_pkg::RRE_Q1, 3'h0});
		rst = 1'b0;
		issue(16'h3712, 8'h01);
		chk(fileWrData, 8'h02);
		chk({sawRd, sawWr}, 2'h3);
		giveVerdict();
	end
endmodule : rre_exec_tb_top
